// ---- logic/wbb_pkg.sv ----
/*
  Shared constants and carrier types for the EEPROM writeback and boot
  message block. Assumes a 100 MHz system clock and a link clock at 64x fs.
*/
package wbb_pkg;
  // ****************************************
  // boot message identifiers
  // ****************************************
  localparam logic [7:0] MSG_END       = 8'h00;
  localparam logic [7:0] MSG_WRITE     = 8'h01;
  localparam logic [7:0] MSG_DELAY     = 8'h02;
  localparam logic [7:0] MSG_NOP       = 8'h03;
  localparam logic [7:0] MSG_MULTI_WB  = 8'h04;
  localparam logic [7:0] MSG_FALL_EDGE = 8'h05;
  localparam logic [7:0] MSG_END_WAIT  = 8'h06;
  // ****************************************
  // eeprom addressing
  // ****************************************
  localparam logic [7:0] EE_CHIP_WR   = 8'hA0;
  localparam logic [7:0] EE_ADDR_HI   = 8'h00;
  localparam logic [7:0] EE_ADDR_LO   = 8'h20;
  localparam int         IF_BYTES     = 32;
  localparam int         WB_OVERHEAD  = 3;
  localparam logic [5:0] WB_LAST_BYTE = 6'(IF_BYTES + WB_OVERHEAD - 1);
  // ****************************************
  // control path map
  // ****************************************
  localparam logic [11:0] IF_BASE_ADDR   = 12'h800;
  localparam logic [11:0] CORE_CTRL_ADDR = 12'h81C;
  localparam int          CORE_IF_WE_BIT = 6;
  localparam logic [15:0] CORE_CTRL_RST  = 16'h0000;
  // ****************************************
  // serial clock shape: 8 link cycles per scl period, 3 high
  // ****************************************
  localparam logic [2:0] SCL_HIGH_FIRST = 3'h4;
  localparam logic [2:0] SCL_HIGH_LAST  = 3'h6;
  localparam logic [2:0] SDA_SAMPLE     = 3'h5;
  localparam logic [2:0] PH_LAST        = 3'h7;
  localparam int         SCL_KHZ        = 384;
  localparam int         WB_TIME_US     = 73;

  typedef struct packed {
    logic        we;
    logic [11:0] addr;
    logic [31:0] data;
  } wbb_ctl_wr_t;

  typedef struct packed {
    logic        we;
    logic [2:0]  idx;
    logic [31:0] data;
  } wbb_dsp_wr_t;

  typedef struct packed {
    logic        valid;
    logic [11:0] addr;
    logic [7:0]  data;
  } wbb_fwd_t;
endpackage

// ---- logic/wbb_writeback.sv ----
/*
  Boot message interpreter, interface registers, and EEPROM writeback
  master. Assumes boot bytes arrive from an EEPROM reader on ref_clk and
  that link_clk runs free at 64x fs, so scl is 8x fs.
*/
// Operation
// R1: in self-boot, a rising trigger pin edge starts a writeback by default.
// R2: a falling-edge message makes the falling trigger edge start writeback.
// R3: only one writeback unless the multiple-writeback message was seen.
// R4: write-protect line is pulled low when a writeback is triggered.
// R5: writeback sends only interface register contents.
// R6: control writes reach interface registers only when core bit 6 is set.
// R7: interface data goes to EEPROM bytes 32 to 63, the second page.
// R8: image holds a six-byte write header for interface data at byte 26.
// R9: image starts with a core control write enabling interface writes.
// R10: EEPROM is addressed at chip address 0xA0 and strapped to answer.
// R11: a writeback sends at most 35 bytes, 3 of them addressing.
// R12: at 384 kHz scl the writeback completes about 73 us after trigger; the code spends 317 scl periods, about 825 us.
// R13: ids decoded: 0x00 end, 0x02 delay with two bytes, 0x06 end-and-wait.
// R14: a write reads two length bytes then consumes exactly that many bytes.
// R15: a no-op byte is a complete message with no effect.
// R16: first byte of each message is its type identifier.
// R17: write bodies begin with zero chip byte then two address bytes.
// R18: scl is eight times fs with a three-eighths duty cycle.
// R19: self-boot starts at reset release only with boot and protect pins high.
// R20: trigger edges during a writeback in progress are ignored.
module wbb_writeback import wbb_pkg::*; (
  // clocks and reset
  input  wire logic        ref_clk,
  input  wire logic        srst,
  input  wire logic        link_clk,
  // straps and trigger
  input  wire logic        selfboot_pin,
  input  wire logic        writeback_trigger_pin,
  // boot image byte stream
  input  wire logic        boot_valid,
  input  wire logic [7:0]  boot_byte,
  output logic             boot_ready,
  output logic             boot_done,
  output wbb_fwd_t         boot_fwd,
  // control path and dsp side
  input  wire wbb_ctl_wr_t ctl_wr,
  input  wire wbb_dsp_wr_t dsp_wr,
  output logic [15:0]      core_ctrl,
  // status
  output logic             self_boot,
  output logic             wb_busy,
  // eeprom pins
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  output logic             scl_out,
  output logic             scl_oe,
  input  wire logic        wp_in,
  output logic             wp_out,
  output logic             wp_oe
);
  typedef enum logic [2:0] {
    B_ID, B_LEN_HI, B_LEN_LO, B_BODY, B_DLY_HI, B_DLY_LO, B_DELAY, B_DONE
  } wbb_boot_st_t;
  typedef enum logic [2:0] {L_IDLE, L_START, L_BIT, L_ACK, L_STOP} wbb_link_st_t;

  function automatic logic is_if(input logic [11:0] a);
    return a[11:3] == IF_BASE_ADDR[11:3];
  endfunction

  wbb_boot_st_t bst;
  wbb_link_st_t lst;
  logic [1:0]   sb_sync, wpi_sync, lrst_sync, sda_sync;
  logic [2:0]   trig_sync, done_sync, req_sync;
  logic         srst_d, take, multi_wb, fall_edge, wb_used, req_tgl, done_tgl;
  logic         trig_edge, wb_start, done_edge, req_edge, if_wr_en, ack_bad;
  logic [15:0]  msg_len, body_cnt, dly_cnt;
  logic [11:0]  body_addr;
  logic [31:0]  word_acc;
  logic [2:0]   word_cnt, word_len, phase, bit_cnt;
  logic [5:0]   byte_idx;
  logic [7:0]   cur_byte;
  logic [31:0]  ifr [8];
  logic [7:0]   snap [IF_BYTES];
  wbb_ctl_wr_t  boot_wr, cp;

  // ****************************************
  // pin synchronisers and strap capture
  // ****************************************
  always_ff @(posedge ref_clk) begin
    sb_sync   <= {sb_sync[0], selfboot_pin};
    wpi_sync  <= {wpi_sync[0], wp_in};
    trig_sync <= {trig_sync[1:0], writeback_trigger_pin};
    done_sync <= {done_sync[1:0], done_tgl};
    srst_d    <= srst;
  end

  // R19 strap sample at release
  always_ff @(posedge ref_clk) begin
    if (srst)
      self_boot <= 1'b0;
    else if (srst_d)
      self_boot <= sb_sync[1] & wpi_sync[1];
  end

  // ****************************************
  // boot message interpreter
  // ****************************************
  assign take = boot_valid & boot_ready;

  // R16 type byte first
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      bst        <= B_ID;
      boot_ready <= 1'b1;
      boot_done  <= 1'b0;
      msg_len    <= '0;
      body_cnt   <= '0;
      dly_cnt    <= '0;
    end else begin
      case (bst)
        B_ID: if (take) begin
          // R13 R15 id decode; no-op and unknown ids are one byte
          case (boot_byte)
            MSG_WRITE: bst <= B_LEN_HI;
            MSG_DELAY: bst <= B_DLY_HI;
            MSG_END, MSG_END_WAIT: begin
              bst        <= B_DONE;
              boot_ready <= 1'b0;
              boot_done  <= 1'b1;
            end
            default: bst <= B_ID;
          endcase
        end
        B_LEN_HI: if (take) begin
          msg_len[15:8] <= boot_byte;
          bst           <= B_LEN_LO;
        end
        // R14 length then body
        B_LEN_LO: if (take) begin
          msg_len[7:0] <= boot_byte;
          body_cnt     <= '0;
          bst          <= ({msg_len[15:8], boot_byte} == '0) ? B_ID : B_BODY;
        end
        B_BODY: if (take) begin
          body_cnt <= body_cnt + 16'h0001;
          if (body_cnt + 16'h0001 == msg_len)
            bst <= B_ID;
        end
        B_DLY_HI: if (take) begin
          dly_cnt[15:8] <= boot_byte;
          bst           <= B_DLY_LO;
        end
        // R13 delay stalls the stream
        B_DLY_LO: if (take) begin
          dly_cnt[7:0] <= boot_byte;
          boot_ready   <= 1'b0;
          bst          <= B_DELAY;
        end
        B_DELAY: begin
          if (dly_cnt == '0) begin
            boot_ready <= 1'b1;
            bst        <= B_ID;
          end else
            dly_cnt <= dly_cnt - 16'h0001;
        end
        B_DONE: bst <= B_DONE;
        default: bst <= B_ID;
      endcase
    end
  end

  // R2 R3 option messages
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      multi_wb  <= 1'b0;
      fall_edge <= 1'b0;
    end else if (bst == B_ID && take) begin
      if (boot_byte == MSG_MULTI_WB)
        multi_wb <= 1'b1;
      if (boot_byte == MSG_FALL_EDGE)
        fall_edge <= 1'b1;
    end
  end

  // ****************************************
  // write body: chip byte, address, then words
  // ****************************************
  assign word_len = is_if(body_addr) ? 3'h4 : (body_addr == CORE_CTRL_ADDR) ? 3'h2 : 3'h0;

  // R17 body header skipped; unknown targets pass out byte-wise
  always_ff @(posedge ref_clk) begin
    if (srst) begin
      body_addr <= '0;
      word_acc  <= '0;
      word_cnt  <= '0;
      boot_wr   <= '0;
      boot_fwd  <= '0;
    end else begin
      boot_wr.we     <= 1'b0;
      boot_fwd.valid <= 1'b0;
      if (bst == B_BODY && take) begin
        if (body_cnt == 16'h0001)
          body_addr[11:8] <= boot_byte[3:0];
        else if (body_cnt == 16'h0002) begin
          body_addr[7:0] <= boot_byte;
          word_cnt       <= '0;
        end else if (body_cnt > 16'h0002) begin
          if (word_len == 3'h0)
            boot_fwd <= '{valid: 1'b1, addr: body_addr, data: boot_byte};
          else if (word_cnt + 3'h1 == word_len) begin
            boot_wr   <= '{we: 1'b1, addr: body_addr, data: {word_acc[23:0], boot_byte}};
            body_addr <= body_addr + 12'h001;
            word_cnt  <= '0;
          end else begin
            word_acc <= {word_acc[23:0], boot_byte};
            word_cnt <= word_cnt + 3'h1;
          end
        end
      end
    end
  end

  // ****************************************
  // core control and interface registers
  // ****************************************
  // boot-time writes take the control path ahead of the host port
  assign cp = boot_wr.we ? boot_wr : ctl_wr;
  // R6 interface write gate
  assign if_wr_en = cp.we && is_if(cp.addr) && core_ctrl[CORE_IF_WE_BIT];

  always_ff @(posedge ref_clk) begin
    if (srst)
      core_ctrl <= CORE_CTRL_RST;
    else if (cp.we && cp.addr == CORE_CTRL_ADDR)
      core_ctrl <= cp.data[15:0];
  end

  always_ff @(posedge ref_clk) begin
    if (srst) begin
      for (int i = 0; i < 8; i++)
        ifr[i] <= '0;
    end else begin
      if (dsp_wr.we)
        ifr[dsp_wr.idx] <= dsp_wr.data;
      if (if_wr_en)
        ifr[cp.addr[2:0]] <= cp.data;
    end
  end

  // ****************************************
  // writeback trigger
  // ****************************************
  // R1 R2 edge polarity
  assign trig_edge = fall_edge ? (~trig_sync[1] & trig_sync[2]) : (trig_sync[1] & ~trig_sync[2]);
  // R3 R20 one shot unless multiple, none while busy
  assign wb_start  = trig_edge && self_boot && boot_done && !wb_busy && (multi_wb || !wb_used);
  assign done_edge = done_sync[1] ^ done_sync[2];

  // R4 protect line held low for the transfer
  always_ff @(posedge ref_clk) begin
    wp_out <= 1'b0;
    if (srst) begin
      wb_busy <= 1'b0;
      wb_used <= 1'b0;
      wp_oe   <= 1'b0;
      req_tgl <= 1'b0;
    end else if (wb_start) begin
      wb_busy <= 1'b1;
      wb_used <= 1'b1;
      wp_oe   <= 1'b1;
      req_tgl <= ~req_tgl;
    end else if (done_edge) begin
      wb_busy <= 1'b0;
      wp_oe   <= 1'b0;
    end
  end

  // R5 snapshot of interface registers only, held stable while busy
  always_ff @(posedge ref_clk) begin
    if (wb_start)
      for (int i = 0; i < IF_BYTES; i++)
        snap[i] <= ifr[i / 4][31 - 8 * (i % 4) -: 8];
  end

  // ****************************************
  // link domain: i2c master
  // ****************************************
  logic lrst;
  assign lrst     = lrst_sync[1];
  assign req_edge = req_sync[1] ^ req_sync[2];

  always_ff @(posedge link_clk) begin
    lrst_sync <= {lrst_sync[0], srst};
    req_sync  <= {req_sync[1:0], req_tgl};
    sda_sync  <= {sda_sync[0], sda_in};
  end

  // R10 R7 chip byte, then page two address
  always_comb begin
    case (byte_idx)
      6'd0: cur_byte = EE_CHIP_WR;
      6'd1: cur_byte = EE_ADDR_HI;
      6'd2: cur_byte = EE_ADDR_LO;
      default: cur_byte = snap[5'(byte_idx - 6'd3)];
    endcase
  end

  // R12 each slot is one scl period; 35 bytes of 9 bits bound the time
  always_ff @(posedge link_clk) begin
    if (lrst) begin
      lst      <= L_IDLE;
      phase    <= '0;
      bit_cnt  <= '0;
      byte_idx <= '0;
      ack_bad  <= 1'b0;
      done_tgl <= 1'b0;
    end else begin
      phase <= (lst == L_IDLE) ? 3'h0 : phase + 3'h1;
      case (lst)
        L_IDLE: if (req_edge) begin
          lst      <= L_START;
          byte_idx <= '0;
          bit_cnt  <= 3'h7;
        end
        L_START: if (phase == PH_LAST)
          lst <= L_BIT;
        L_BIT: if (phase == PH_LAST) begin
          if (bit_cnt == 3'h0)
            lst <= L_ACK;
          bit_cnt <= bit_cnt - 3'h1;
        end
        L_ACK: begin
          if (phase == SDA_SAMPLE)
            ack_bad <= sda_sync[1];
          // R11 stop after the last byte or a refused byte
          if (phase == PH_LAST) begin
            if (ack_bad || byte_idx == WB_LAST_BYTE)
              lst <= L_STOP;
            else begin
              lst      <= L_BIT;
              byte_idx <= byte_idx + 6'd1;
              bit_cnt  <= 3'h7;
            end
          end
        end
        L_STOP: if (phase == PH_LAST) begin
          lst      <= L_IDLE;
          done_tgl <= ~done_tgl;
        end
        default: lst <= L_IDLE;
      endcase
    end
  end

  // R18 scl high for phases 4..6 of each bit and ack slot; sda moves only after phase 0
  always_ff @(posedge link_clk) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
    if (lrst) begin
      scl_oe <= 1'b0;
      sda_oe <= 1'b0;
    end else begin
      case (lst)
        L_BIT, L_ACK: scl_oe <= phase < SCL_HIGH_FIRST || phase > SCL_HIGH_LAST;
        L_STOP:       scl_oe <= phase < SCL_HIGH_FIRST;
        default:      scl_oe <= 1'b0;
      endcase
      case (lst)
        L_IDLE:  sda_oe <= 1'b0;
        L_START: sda_oe <= phase >= SDA_SAMPLE;
        L_BIT:   if (phase != 3'h0) sda_oe <= ~cur_byte[bit_cnt];
        L_ACK:   if (phase != 3'h0) sda_oe <= 1'b0;
        L_STOP:  if (phase != 3'h0) sda_oe <= phase < SDA_SAMPLE;
        default: sda_oe <= 1'b0;
      endcase
    end
  end

  // ****************************************
  // checks
  // ****************************************
  logic [1:0]  wb_starts;
  logic [2:0]  gate_idx;
  logic [31:0] gate_val;
  always_ff @(posedge ref_clk) begin
    if (srst)
      wb_starts <= '0;
    else if (wb_start && wb_starts != 2'h3)
      wb_starts <= wb_starts + 2'h1;
    gate_idx <= ctl_wr.addr[2:0];
    gate_val <= ifr[ctl_wr.addr[2:0]];
  end

  wp_pull_a: assert property (@(posedge ref_clk) disable iff (srst) // R4
    wb_start |=> wb_busy && wp_oe && !wp_out) else $error("protect line not pulled");
  busy_ignore_a: assert property (@(posedge ref_clk) disable iff (srst) // R20
    wb_busy && trig_edge |=> $stable(req_tgl)) else $error("trigger taken while busy");
  one_shot_a: assert property (@(posedge ref_clk) disable iff (srst) // R3
    !multi_wb |-> wb_starts <= 2'h1) else $error("second writeback without option");
  edge_sel_a: assert property (@(posedge ref_clk) disable iff (srst) // R2
    wb_start |-> trig_sync[1] == !fall_edge && trig_sync[2] == fall_edge)
    else $error("writeback on wrong edge");
  if_gate_a: assert property (@(posedge ref_clk) disable iff (srst) // R6
    ctl_wr.we && !boot_wr.we && !dsp_wr.we && is_if(ctl_wr.addr)
    && !core_ctrl[CORE_IF_WE_BIT] |=> ifr[gate_idx] == gate_val)
    else $error("interface write while gated");
  nop_a: assert property (@(posedge ref_clk) disable iff (srst) // R15
    bst == B_ID && take && boot_byte == MSG_NOP |=> bst == B_ID && boot_ready)
    else $error("no-op not single byte");
  body_len_a: assert property (@(posedge ref_clk) disable iff (srst) // R14
    bst == B_BODY && take && body_cnt + 16'h0001 == msg_len |=> bst == B_ID)
    else $error("write body length wrong");
  end_wait_a: assert property (@(posedge ref_clk) disable iff (srst) // R13
    bst == B_ID && take && boot_byte == MSG_END_WAIT |=> boot_done && !boot_ready[*3])
    else $error("end message not final");
  strap_a: assert property (@(posedge ref_clk) disable iff (srst) // R19
    $rose(self_boot) |-> $past(sb_sync[1]) && $past(wpi_sync[1]))
    else $error("self-boot without straps");
  scl_duty_a: assert property (@(posedge link_clk) disable iff (lrst) // R18
    $fell(scl_oe) && (lst == L_BIT || lst == L_ACK) |-> !scl_oe[*3] ##1 scl_oe)
    else $error("scl high time not 3 of 8");
  // the drive enable sda_oe is checked, one cycle after the bit is launched
  chip_addr_a: assert property (@(posedge link_clk) disable iff (lrst) // R10
    lst == L_BIT && byte_idx == 6'h00 && phase == 3'h2 |-> sda_oe == !EE_CHIP_WR[bit_cnt])
    else $error("bad chip byte");
  page_addr_a: assert property (@(posedge link_clk) disable iff (lrst) // R7
    lst == L_BIT && byte_idx == 6'h02 && phase == 3'h2 |-> sda_oe == !EE_ADDR_LO[bit_cnt])
    else $error("not page two");
  byte_cap_a: assert property (@(posedge link_clk) disable iff (lrst) // R11
    lst == L_STOP |-> byte_idx <= 6'd34) else $error("more than 35 bytes");

  wb_c:    cover property (@(posedge ref_clk) disable iff (srst) wb_start);
  fall_c:  cover property (@(posedge ref_clk) disable iff (srst) wb_start && fall_edge);
  multi_c: cover property (@(posedge ref_clk) disable iff (srst) wb_start && wb_starts == 2'h1);
  delay_c: cover property (@(posedge ref_clk) disable iff (srst) bst == B_DELAY);
endmodule // wbb_writeback

// ---- test/tb_eeprom_writeback_boot_messages.sv ----
/*
  Self-checking bench for the writeback and boot message block: feeds boot
  images, makes control and dsp writes, triggers writebacks and checks what
  the EEPROM model logged. Assumes pull-ups on SDA, SCL and WP.
*/
module tb_eeprom_writeback_boot_messages import wbb_pkg::*;;
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // pins and instances
  // ****************************************
  logic        ref_clk, srst, link_clk, selfboot_pin, writeback_trigger_pin;
  logic        boot_valid, boot_ready, boot_done, self_boot, wb_busy;
  logic [7:0]  boot_byte;
  logic [15:0] core_ctrl;
  wbb_fwd_t    boot_fwd;
  wbb_fwd_t    fwd_first;
  wbb_ctl_wr_t ctl_wr;
  wbb_dsp_wr_t dsp_wr;
  logic        sda_in, sda_out, sda_oe, scl_out, scl_oe;
  logic        wp_in, wp_out, wp_oe, ee_pull, wp_low, armed;
  logic [31:0] ifr_exp [8];
  logic [15:0] core_exp;
  int          miscompares = 0;
  int          comparisons = 0;
  int          seed = 37097;
  int          last_wait, fwd_n = 0, hi_n = 0;
  assign sda_in = ~(sda_oe | ee_pull);
  assign wp_in  = ~(wp_oe | wp_low);
  wbb_writeback wbb_writeback_inst (
    .ref_clk, .srst, .link_clk, .selfboot_pin, .writeback_trigger_pin,
    .boot_valid, .boot_byte, .boot_ready, .boot_done, .boot_fwd, .ctl_wr,
    .dsp_wr, .core_ctrl, .self_boot, .wb_busy, .sda_in, .sda_out, .sda_oe,
    .scl_out, .scl_oe, .wp_in, .wp_out, .wp_oe
  );
  wbb_eeprom_model wbb_eeprom_model_inst (.scl(~scl_oe), .sda(sda_in), .sda_pull(ee_pull));
  initial begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  initial begin
    link_clk = 1'b0;
    #3.3;
    forever #62.5 link_clk = ~link_clk;
  end
  // ****************************************
  // tasks
  // ****************************************
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic final_report;
    if (miscompares == 0 && comparisons > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
  endtask
  // valid stays up between bytes; each byte re-asserts it and then waits for boot_ready
  task automatic put(input logic [7:0] b);
    last_wait = 0;
    boot_valid <= 1'b1;
    boot_byte  <= b;
    @(posedge ref_clk);
    while (boot_ready !== 1'b1 && last_wait < 500) begin
      @(posedge ref_clk);
      last_wait++;
    end
  endtask
  task automatic puts(input logic [7:0] q[$]);
    foreach (q[i]) put(q[i]);
  endtask
  task automatic host(input logic [11:0] a, input logic [31:0] d);
    ctl_wr <= '{we: 1'b1, addr: a, data: d};
    if (a == CORE_CTRL_ADDR) core_exp = d[15:0];
    else if (core_exp[CORE_IF_WE_BIT]) ifr_exp[a[2:0]] = d;
    @(posedge ref_clk);
    ctl_wr.we <= 1'b0;
    @(posedge ref_clk);
    chk("core_ctrl", core_exp, core_ctrl);
  endtask
  task automatic dsp(input logic [2:0] k, input logic [31:0] d);
    dsp_wr <= '{we: 1'b1, idx: k, data: d};
    ifr_exp[k] = d;
    @(posedge ref_clk);
    dsp_wr.we <= 1'b0;
    @(posedge ref_clk);
  endtask
  task automatic do_reset(input logic wpl);
    wp_low <= wpl;
    srst   <= 1'b1;
    tick(40);
    srst   <= 1'b0;
    tick(2);
    chk("self_boot", !wpl, self_boot);
    wp_low <= 1'b0;
  endtask
  function automatic logic [7:0] exp_byte(input int i);
    if (i == 0) return EE_CHIP_WR;
    if (i < 3) return (i == 1) ? EE_ADDR_HI : EE_ADDR_LO;
    return ifr_exp[(i - 3) / 4][31 - 8 * ((i - 3) % 4) -: 8];
  endfunction
  // a second edge mid-transfer must be ignored
  task automatic run_wb(input logic lvl);
    int  n;
    time t0;
    n = 0;
    writeback_trigger_pin <= lvl;
    while (wb_busy !== 1'b1 && n < 10) begin
      @(posedge ref_clk);
      n++;
    end
    t0 = $time;
    tick(1);
    chk("wp_oe", 1, wp_oe);
    chk("wp_in", 0, wp_in);
    chk("pin_lows", 0, {sda_out, scl_out, wp_out});
    tick(1000);
    writeback_trigger_pin <= ~lvl;
    tick(300);
    writeback_trigger_pin <= lvl;
    n = 0;
    while (wb_busy === 1'b1 && n < 40000) begin
      @(posedge ref_clk);
      n++;
    end
    chk("wb_ns", 1, ($time - t0) inside {[316000:320000]});
    chk("wb_nbytes", 35, wbb_eeprom_model_inst.nrx);
    for (int i = 0; i < 35; i++)
      chk("wb_byte", exp_byte(i), wbb_eeprom_model_inst.rx[i]);
    tick(20);
    chk("wb_busy", 0, wb_busy);
    chk("wp_oe", 0, wp_oe);
    writeback_trigger_pin <= ~lvl;
    tick(5);
  endtask
  // ****************************************
  // monitors
  // ****************************************
  always @(posedge ref_clk) if (boot_fwd.valid === 1'b1) begin
    if (fwd_n == 0) fwd_first <= boot_fwd;
    fwd_n <= fwd_n + 1;
  end
  // scl high time, counted only for pulses that rose during a transfer
  always @(posedge ref_clk) begin
    if (wb_busy !== 1'b1) begin
      hi_n  <= 0;
      armed <= 1'b0;
    end else if (scl_oe === 1'b0) begin
      if (armed) hi_n <= hi_n + 1;
    end else begin
      if (hi_n != 0) chk("scl_high", 1, hi_n inside {[36:39]});
      hi_n  <= 0;
      armed <= 1'b1;
    end
  end
  initial begin
    #900us;
    miscompares++;
    final_report();
  end
  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    logic [7:0] b;
    srst = 1'b1;
    selfboot_pin = 1'b1;
    writeback_trigger_pin = 1'b0;
    boot_valid = 1'b0;
    boot_byte = 8'h00;
    ctl_wr = '0;
    dsp_wr = '0;
    wp_low = 1'b0;
    core_exp = 16'h0000;
    @(posedge ref_clk);
    do_reset(1'b0);
    puts({MSG_WRITE, 8'h00, 8'h05, 8'h00, 8'h08, 8'h1C, 8'h00, 8'h40});
    core_exp = 16'h0040;
    repeat (18) put(MSG_NOP);
    puts({MSG_WRITE, 8'h00, 8'h23, 8'h00, 8'h08, 8'h00});
    for (int i = 0; i < 32; i++) begin
      b = 8'($random(seed));
      put(b);
      ifr_exp[i / 4][31 - 8 * (i % 4) -: 8] = b;
    end
    put(MSG_MULTI_WB);
    puts({MSG_WRITE, 8'h00, 8'h05, 8'h00, 8'h04, 8'h00, 8'hAB, 8'hCD});
    puts({MSG_DELAY, 8'h00, 8'h05, MSG_END_WAIT});
    chk("delay_wait", 1, last_wait inside {[5:8]});
    boot_valid <= 1'b0;
    tick(3);
    chk("boot_done", 1, boot_done);
    chk("boot_ready", 0, boot_ready);
    chk("core_ctrl", 16'h0040, core_ctrl);
    chk("fwd_count", 2, fwd_n);
    chk("fwd_addr", 12'h400, fwd_first.addr);
    chk("fwd_data", 8'hAB, fwd_first.data);
    host(CORE_CTRL_ADDR, 32'h0000_0000);
    host(IF_BASE_ADDR + 12'h002, $random(seed));
    host(CORE_CTRL_ADDR, 32'h0000_0040);
    host(IF_BASE_ADDR + 12'h005, $random(seed));
    dsp(3'h1, $random(seed));
    run_wb(1'b1);
    dsp(3'($random(seed)), $random(seed));
    run_wb(1'b1);
    // falling-edge mode, single writeback, reset aborts the transfer
    do_reset(1'b0);
    puts({MSG_WRITE, 8'h00, 8'h05, 8'h00, 8'h08, 8'h1C, 8'h00, 8'h40, MSG_FALL_EDGE, MSG_END});
    boot_valid <= 1'b0;
    tick(3);
    chk("boot_done", 1, boot_done);
    writeback_trigger_pin <= 1'b1;
    tick(10);
    chk("wb_rise", 0, wb_busy);
    writeback_trigger_pin <= 1'b0;
    tick(6);
    chk("wb_fall", 1, wb_busy);
    chk("wp_oe", 1, wp_oe);
    do_reset(1'b1);
    final_report();
  end
endmodule // tb_eeprom_writeback_boot_messages

// ---- test/wbb_eeprom_model.sv ----
/*
  Behavioural serial EEPROM slave for the writeback bench; logs the first 64 bytes
  of a write transfer. Assumes the bench resolves SDA and SCL as pulled-up
  open-drain wires and feeds their levels here.
*/
module wbb_eeprom_model #(
  parameter logic [7:0] STRAP_ADDR = 8'hA0
) (
  // bus wires
  input  wire logic scl,
  input  wire logic sda,
  // data line pull-down
  output logic      sda_pull
);
  timeunit 1ns;
  timeprecision 100ps;
  // ****************************************
  // slave receiver
  // ****************************************
  logic [7:0] rx [0:63];
  logic [7:0] sh;
  int         nbit = 0;
  int         nrx = 0;
  logic       active = 1'b0;
  initial sda_pull = 1'b0;
  // start clears the byte log, stop ends the frame
  always @(negedge sda) if (scl === 1'b1) begin
    active = 1'b1;
    nbit   = 0;
    nrx    = 0;
  end
  always @(posedge sda) if (scl === 1'b1) active = 1'b0;
  always @(posedge scl) if (active) begin
    if (nbit == 8) nbit = 0;
    else begin
      sh   = {sh[6:0], sda};
      nbit = nbit + 1;
    end
  end
  always @(negedge scl) begin
    sda_pull = active && nbit == 8 && (nrx != 0 || sh == STRAP_ADDR);
    if (active && nbit == 8) begin
      if (nrx < 64) rx[nrx] = sh;
      nrx = nrx + 1;
    end
  end
endmodule // wbb_eeprom_model
